// file: common/lpi_pkg.sv
// Package for the device-side LPDDR3 power-up and initialization tracker.
// Assumes a single core clock at 40 MHz; times are converted to cycles here.
package lpi_pkg;
  localparam int ClkPeriodNs = 25;
  localparam int Init5MaxUs = 10;
  localparam int Init5Cycles = (Init5MaxUs * 1000) / ClkPeriodNs;
  localparam int ZqInitUs = 1;
  localparam int ZqInitCycles = (ZqInitUs * 1000 + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int CntWidth = 16;
  localparam logic [7:0] MrDevInfo = 8'h00;
  localparam logic [7:0] MrZqCal = 8'h0a;
  localparam logic [7:0] MrOdt = 8'h0b;
  localparam logic [7:0] MrReset = 8'h3f;
  localparam int DaiBit = 0;
  localparam int OdtEnBit = 0;
  localparam logic [7:0] Mr0Reset = 8'h01;
  localparam logic [7:0] Mr11Reset = 8'h00;
  typedef enum logic [2:0] {
    ST_PWRUP,
    ST_WAIT_RESET,
    ST_AUTO_INIT,
    ST_IDLE,
    ST_ZQ_CAL,
    ST_READY
  } lpi_state_e;
endpackage

// file: verilog/lpi_timer.sv
// Down-counter that signals expiry of a loaded interval.
// Assumes load and count come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module lpi_timer (
  input wire logic coreClk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic load,
  input wire logic [lpi_pkg::CntWidth-1:0] loadValue,
  output logic expired
);
  logic [lpi_pkg::CntWidth-1:0] cnt_reg;
  logic [lpi_pkg::CntWidth-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = loadValue;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge coreClk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (clkEn) begin
      cnt_reg <= cnt_next;
    end
  end

  assign expired = (cnt_reg == '0) && !load;
endmodule
`default_nettype wire

// file: verilog/lpi_init_seq.sv
// Device-side initialization state tracker for an LPDDR3 memory die.
// Assumes decoded commands from the same clock domain; CKE and ODT pins
// arrive unsynchronised and pass two flip-flops first.
`timescale 1ns/1ps
`default_nettype none
module lpi_init_seq (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic ckePin,
  input wire logic odtPin,
  input wire logic caFloating,
  input wire logic cmdValid,
  input wire logic cmdIsMrw,
  input wire logic cmdIsMrr,
  input wire logic [7:0] cmdAddr,
  input wire logic [7:0] cmdData,
  input wire logic outDriveReq,
  output logic outEnable_n,
  output logic odtActive,
  output logic [7:0] mrrData,
  output logic mrrValid,
  output logic daiBusy,
  output logic deviceIdle,
  output logic deviceReady
);
  logic ckeMeta_reg, ckeSync_reg, odtMeta_reg, odtSync_reg;
  lpi_pkg::lpi_state_e state_reg, state_next;
  logic [7:0] mr0_reg, mr0_next, mr11_reg, mr11_next;
  logic [7:0] mrrData_reg, mrrData_next;
  logic mrrValid_reg, mrrValid_next;
  logic tLoad;
  logic [lpi_pkg::CntWidth-1:0] tValue;
  logic tExpired;
  logic cmdLive, isReset, isZq, isMrr0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ckeMeta_reg <= 1'b0;
      ckeSync_reg <= 1'b0;
      odtMeta_reg <= 1'b0;
      odtSync_reg <= 1'b0;
    end else if (clkEn) begin
      ckeMeta_reg <= ckePin;
      ckeSync_reg <= ckeMeta_reg;
      odtMeta_reg <= odtPin;
      odtSync_reg <= odtMeta_reg;
    end
  end

  // Floating bus decodes as NOP, so no command is seen
  assign cmdLive = cmdValid && !caFloating && ckeSync_reg;
  assign isReset = cmdLive && cmdIsMrw && (cmdAddr == lpi_pkg::MrReset);
  assign isZq = cmdLive && cmdIsMrw && (cmdAddr == lpi_pkg::MrZqCal);
  assign isMrr0 = cmdLive && cmdIsMrr && (cmdAddr == lpi_pkg::MrDevInfo);

  lpi_timer uTimer (
    .coreClk(core_clk),
    .rst(rst),
    .clkEn(clkEn),
    .load(tLoad),
    .loadValue(tValue),
    .expired(tExpired)
  );

  always_comb begin
    state_next = state_reg;
    mr0_next = mr0_reg;
    mr11_next = mr11_reg;
    mrrData_next = mrrData_reg;
    mrrValid_next = 1'b0;
    tLoad = 1'b0;
    tValue = '0;
    if (isReset) begin
      // Reset from any state restarts the sequence
      state_next = lpi_pkg::ST_AUTO_INIT;
      mr0_next = lpi_pkg::Mr0Reset;
      mr11_next = lpi_pkg::Mr11Reset;
      tLoad = 1'b1;
      // State advances one edge after the timer reaches zero, so load one short
      tValue = lpi_pkg::CntWidth'(lpi_pkg::Init5Cycles - 1);
    end else begin
      case (state_reg)
        lpi_pkg::ST_PWRUP: begin
          if (ckeSync_reg) begin
            state_next = lpi_pkg::ST_WAIT_RESET;
          end
        end
        lpi_pkg::ST_WAIT_RESET: begin
          state_next = lpi_pkg::ST_WAIT_RESET;
        end
        lpi_pkg::ST_AUTO_INIT: begin
          if (tExpired) begin
            mr0_next[lpi_pkg::DaiBit] = 1'b0;
            state_next = lpi_pkg::ST_IDLE;
          end
        end
        lpi_pkg::ST_IDLE: begin
          if (isZq) begin
            state_next = lpi_pkg::ST_ZQ_CAL;
            tLoad = 1'b1;
            tValue = lpi_pkg::CntWidth'(lpi_pkg::ZqInitCycles - 1);
          end
        end
        lpi_pkg::ST_ZQ_CAL: begin
          if (tExpired) begin
            state_next = lpi_pkg::ST_READY;
          end
        end
        lpi_pkg::ST_READY: begin
          if (cmdLive && cmdIsMrw && cmdAddr == lpi_pkg::MrOdt) begin
            mr11_next = cmdData;
          end
        end
        default: state_next = lpi_pkg::ST_PWRUP;
      endcase
      if (isMrr0) begin
        mrrData_next = mr0_reg;
        mrrValid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= lpi_pkg::ST_PWRUP;
      mr0_reg <= lpi_pkg::Mr0Reset;
      mr11_reg <= lpi_pkg::Mr11Reset;
      mrrData_reg <= 8'h00;
      mrrValid_reg <= 1'b0;
    end else if (clkEn) begin
      state_reg <= state_next;
      mr0_reg <= mr0_next;
      mr11_reg <= mr11_next;
      mrrData_reg <= mrrData_next;
      mrrValid_reg <= mrrValid_next;
    end
  end

  // Drivers stay off whenever synchronised CKE is low, whatever the core asks
  assign outEnable_n = !(ckeSync_reg && outDriveReq);
  assign odtActive = mr11_reg[lpi_pkg::OdtEnBit] && odtSync_reg && ckeSync_reg;
  assign mrrData = mrrData_reg;
  assign mrrValid = mrrValid_reg;
  assign daiBusy = mr0_reg[lpi_pkg::DaiBit];
  assign deviceIdle = (state_reg == lpi_pkg::ST_IDLE);
  assign deviceReady = (state_reg == lpi_pkg::ST_READY);

  // Age of the current auto-init phase; feeds only the bound check
  logic [lpi_pkg::CntWidth-1:0] initAge_reg, initAge_next;

  always_comb begin
    initAge_next = initAge_reg;
    if (isReset) begin
      initAge_next = '0;
    end else if (state_reg == lpi_pkg::ST_AUTO_INIT) begin
      initAge_next = initAge_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      initAge_reg <= '0;
    end else if (clkEn) begin
      initAge_reg <= initAge_next;
    end
  end

  a_hiz_low_cke: assert property (@(posedge core_clk) disable iff (rst)
    !ckeSync_reg |-> outEnable_n) else $error("Outputs driven with CKE low");
  a_reset_dai_set: assert property (@(posedge core_clk) disable iff (rst)
    (isReset && clkEn) |=> daiBusy) else $error("DAI not set after reset");
  a_auto_init_max: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == lpi_pkg::ST_AUTO_INIT) |->
      (initAge_reg < lpi_pkg::CntWidth'(lpi_pkg::Init5Cycles)))
    else $error("Auto-init longer than its maximum");
  a_odt_off_reset: assert property (@(posedge core_clk) disable iff (rst)
    (isReset && clkEn) |=> !odtActive) else $error("ODT active after reset");
  a_ready_after_zq: assert property (@(posedge core_clk) disable iff (rst)
    $rose(deviceReady) |-> $past(state_reg) == lpi_pkg::ST_ZQ_CAL)
    else $error("Ready without calibration");
  a_idle_dai_clear: assert property (@(posedge core_clk) disable iff (rst)
    deviceIdle |-> !daiBusy) else $error("Idle with DAI busy");
  a_float_nop: assert property (@(posedge core_clk) disable iff (rst)
    (caFloating && cmdValid && clkEn) |=> !mrrValid)
    else $error("Floating bus acted on");
  a_odt_needs_mr11: assert property (@(posedge core_clk) disable iff (rst)
    odtActive |-> (deviceReady && mr11_reg[lpi_pkg::OdtEnBit]))
    else $error("ODT on before calibration done");
  a_mrr_answer: assert property (@(posedge core_clk) disable iff (rst)
    (isMrr0 && !isReset && clkEn) |=> (mrrValid && mrrData == $past(mr0_reg)))
    else $error("MRR answer wrong");

  c_reset_seen: cover property (@(posedge core_clk) disable iff (rst) isReset);
  c_idle_reached: cover property (@(posedge core_clk) disable iff (rst) $rose(deviceIdle));
  c_ready_reached: cover property (@(posedge core_clk) disable iff (rst) $rose(deviceReady));
  c_odt_on: cover property (@(posedge core_clk) disable iff (rst) $rose(odtActive));
endmodule
`default_nettype wire

// file: tb/lpi_ctrl_model.sv
// Controller model: drives CKE, ODT and decoded commands.
// Assumes the bench calls its tasks; nothing moves between calls.
`timescale 1ns/1ps
`default_nettype none
module lpi_ctrl_model (
  input wire logic core_clk,
  output logic ckePin,
  output logic odtPin,
  output logic caFloating,
  output logic cmdValid,
  output logic cmdIsMrw,
  output logic cmdIsMrr,
  output logic [7:0] cmdAddr,
  output logic [7:0] cmdData
);
  initial begin
    ckePin = 1'b0;
    odtPin = 1'b1;
    caFloating = 1'b0;
    cmdValid = 1'b0;
    cmdIsMrw = 1'b0;
    cmdIsMrr = 1'b0;
    cmdAddr = 8'h00;
    cmdData = 8'h00;
  end
  task automatic pins(input logic cke, input logic flt);
    @(posedge core_clk);
    ckePin <= cke;
    caFloating <= flt;
  endtask
  // One-cycle strobe; lines inverted after so stale values never match
  task automatic send(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdIsMrw <= wr;
    cmdIsMrr <= !wr;
    cmdAddr <= a;
    cmdData <= d;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    cmdAddr <= ~a;
    cmdData <= ~d;
  endtask
  task automatic odt(input logic v);
    @(posedge core_clk);
    odtPin <= v;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the initialization tracker.
// Assumes lpi_pkg and the controller model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic outDriveReq = 1'b1;
  logic clkEn = 1'b1;
  logic ckePin, odtPin, caFloating, cmdValid, cmdIsMrw, cmdIsMrr;
  logic [7:0] cmdAddr, cmdData, mrrData;
  logic outEnable_n, odtActive, mrrValid, daiBusy, deviceIdle, deviceReady;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int k;
  logic [7:0] expQ[$];
  always #12.5 core_clk = ~core_clk;
  lpi_ctrl_model lpi_ctrl_model_inst (.core_clk(core_clk), .ckePin(ckePin),
    .odtPin(odtPin), .caFloating(caFloating), .cmdValid(cmdValid), .cmdIsMrw(cmdIsMrw),
    .cmdIsMrr(cmdIsMrr), .cmdAddr(cmdAddr), .cmdData(cmdData));
  lpi_init_seq lpi_init_seq_inst (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
    .ckePin(ckePin), .odtPin(odtPin), .caFloating(caFloating), .cmdValid(cmdValid),
    .cmdIsMrw(cmdIsMrw), .cmdIsMrr(cmdIsMrr), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .outDriveReq(outDriveReq), .outEnable_n(outEnable_n), .odtActive(odtActive),
    .mrrData(mrrData), .mrrValid(mrrValid), .daiBusy(daiBusy), .deviceIdle(deviceIdle),
    .deviceReady(deviceReady));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watcher: every read answer consumes the oldest expectation
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 12000) begin
      n_fail++;
      close_out();
    end
    if (mrrValid === 1'b1) begin
      if (expQ.size() == 0) chk("unexpected mrr", 8'h00, 8'hff);
      else chk("mrrData", expQ.pop_front(), mrrData);
    end
  end
  // Full reset-to-ready walk; also used for a mid-run restart
  task automatic boot;
    lpi_ctrl_model_inst.send(1'b1, lpi_pkg::MrReset, 8'($urandom));
    @(negedge core_clk);
    chk("daiBusy", 8'h01, 8'(daiBusy));
    chk("odt after reset", 8'h00, 8'(odtActive));
    lpi_ctrl_model_inst.pins(1'b1, 1'b1);
    lpi_ctrl_model_inst.send(1'b0, lpi_pkg::MrDevInfo, 8'h00);
    lpi_ctrl_model_inst.pins(1'b1, 1'b0);
    lpi_ctrl_model_inst.idle(40);
    expQ.push_back(lpi_pkg::Mr0Reset);
    lpi_ctrl_model_inst.send(1'b0, lpi_pkg::MrDevInfo, 8'h00);
    // Forty-six edges spent after the reset edge; idle must show by edge 400
    for (k = 0; deviceIdle !== 1'b1 && k < lpi_pkg::Init5Cycles - 45; k++) @(negedge core_clk);
    chk("idle in time", 8'h01, 8'(deviceIdle));
    expQ.push_back(lpi_pkg::Mr0Reset & 8'hfe);
    lpi_ctrl_model_inst.send(1'b0, lpi_pkg::MrDevInfo, 8'h00);
    lpi_ctrl_model_inst.send(1'b1, lpi_pkg::MrOdt, 8'h01);
    lpi_ctrl_model_inst.send(1'b1, lpi_pkg::MrZqCal, 8'($urandom));
    for (k = 0; deviceReady !== 1'b1 && k < lpi_pkg::ZqInitCycles + 4; k++) @(negedge core_clk);
    chk("zq time", 8'(lpi_pkg::ZqInitCycles + 1), 8'(k));
    chk("odt before mr11", 8'h00, 8'(odtActive));
    for (int i = 1; i < 4; i++) lpi_ctrl_model_inst.send(1'b1, 8'(i), 8'($urandom));
    lpi_ctrl_model_inst.send(1'b1, lpi_pkg::MrOdt, 8'h01);
    @(negedge core_clk);
    chk("odt enabled", 8'h01, 8'(odtActive));
  endtask
  initial begin
    k = $urandom(32'hd977728d);
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    lpi_ctrl_model_inst.idle(10);
    chk("oen cke low", 8'h01, 8'(outEnable_n));
    lpi_ctrl_model_inst.pins(1'b1, 1'b0);
    lpi_ctrl_model_inst.idle(8000);
    boot();
    boot();
    lpi_ctrl_model_inst.odt(1'b0);
    lpi_ctrl_model_inst.idle(2);
    @(negedge core_clk);
    chk("odt pin low", 8'h00, 8'(odtActive));
    lpi_ctrl_model_inst.odt(1'b1);
    lpi_ctrl_model_inst.idle(2);
    @(negedge core_clk);
    chk("odt pin high", 8'h01, 8'(odtActive));
    @(posedge core_clk);
    clkEn <= 1'b0;
    lpi_ctrl_model_inst.send(1'b1, lpi_pkg::MrOdt, 8'h00);
    @(negedge core_clk);
    chk("odt frozen", 8'h01, 8'(odtActive));
    @(posedge core_clk);
    clkEn <= 1'b1;
    lpi_ctrl_model_inst.send(1'b1, lpi_pkg::MrOdt, 8'h00);
    @(negedge core_clk);
    chk("odt disabled", 8'h00, 8'(odtActive));
    @(posedge core_clk);
    outDriveReq <= 1'($urandom);
    @(negedge core_clk);
    chk("oen cke high", 8'(!outDriveReq), 8'(outEnable_n));
    @(posedge core_clk);
    outDriveReq <= 1'b1;
    lpi_ctrl_model_inst.pins(1'b0, 1'b0);
    lpi_ctrl_model_inst.idle(4);
    chk("oen power off", 8'h01, 8'(outEnable_n));
    lpi_ctrl_model_inst.idle(2);
    chk("queue empty", 8'h00, 8'(expQ.size()));
    close_out();
  end
endmodule
`default_nettype wire
